// ==== dio_pkg.sv ====
// Purpose: Shared constants for the digital I/O port, strobe latch and clock generator block.
// Assumes: Core clock of 10 MHz; host reaches the ports over an 8-bit internal data path.
// Notes: Frequencies are in Hz; dividers are derived from them.
package dio_pkg;
  localparam int PORT_W = 16;
  localparam int BYTE_W = 8;
  localparam int HADDR_W = 2;
  localparam int CNT_W = 16;
  localparam int GP_CHANS = 3;
  // Host address bits: bit 0 picks the byte, bit 1 picks the low or high port.
  localparam int BYTE_SEL_BIT = 0;
  localparam int PORT_SEL_BIT = 1;
  localparam logic [PORT_W-1:0] OUT_RESET = 16'h0000;
  localparam logic [PORT_W-1:0] IN_DISABLED = 16'h0000;
  localparam logic [BYTE_W-1:0] RDATA_RESET = 8'h00;
  // Core clock and internal pacer reference.
  localparam int CLK_HZ = 10_000_000;
  localparam int REF_HZ = 4_000_000;
  localparam int ACC_W = 24;
  localparam logic [ACC_W-1:0] ACC_CLK = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_REF = ACC_W'(REF_HZ);
  // Base clock choices selected by the jumper.
  localparam int BASE_HZ_0 = 2_000_000;
  localparam int BASE_HZ_1 = 1_000_000;
  localparam int BASE_HZ_2 = 500_000;
  localparam int BASE_HZ_3 = 250_000;
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] BASE_DIV_0 = DIV_W'(CLK_HZ / BASE_HZ_0);
  localparam logic [DIV_W-1:0] BASE_DIV_1 = DIV_W'(CLK_HZ / BASE_HZ_1);
  localparam logic [DIV_W-1:0] BASE_DIV_2 = DIV_W'(CLK_HZ / BASE_HZ_2);
  localparam logic [DIV_W-1:0] BASE_DIV_3 = DIV_W'(CLK_HZ / BASE_HZ_3);
  localparam logic [1:0] JUMPER_2M = 2'h0;
  localparam logic [1:0] JUMPER_1M = 2'h1;
  localparam logic [1:0] JUMPER_500K = 2'h2;
  localparam logic [1:0] JUMPER_DEFAULT = JUMPER_1M;
  // Decade dividers: count to ten, high for the first half.
  localparam int DEC_W = 4;
  localparam logic [DEC_W-1:0] DECADE_LAST = 4'h9;
  localparam logic [DEC_W-1:0] DECADE_HALF = 4'h5;
  // Clock output pad positions.
  localparam int PAD_BASE = 0;
  localparam int PAD_DIV10 = 1;
  localparam int PAD_DIV100 = 2;
  localparam int PADS = 3;
endpackage : dio_pkg

// ==== dio_count_chan.sv ====
// Purpose: One 16-bit down-counting timer/counter channel.
// Assumes: tick is a one-cycle pulse in the clk domain.
// Notes: A reload of 0 or 1 gives a terminal pulse on every tick.
`timescale 1ns/1ps
module dio_count_chan #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Count control.
  input wire logic tick,
  input wire logic [W-1:0] reload,
  // Channel state.
  output logic [W-1:0] count,
  output logic terminal
);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  logic at_end;
  logic [W-1:0] next_count;
  assign at_end = (count <= ONE);
  assign next_count = tick ? (at_end ? reload : count - ONE) : count;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
      terminal <= 1'b0;
    end else begin
      count <= next_count;
      terminal <= tick && at_end;
    end
  end

  a_term_needs_tick: assert property (@(posedge clk) disable iff (sys_rst)
    terminal |-> $past(tick)) else $error("terminal pulse without a tick");
endmodule : dio_count_chan

// ==== dio_top.sv ====
// Purpose: Digital I/O ports, strobe latches, counters and clock outputs.
// Assumes: sys_rst is the card reset; pins are asynchronous to clk.
// Notes: A strobe held high (pulled up when undriven) is transparent; low holds.
`timescale 1ns/1ps
module dio_top (
  // Clock and card reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Host byte access.
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [dio_pkg::HADDR_W-1:0] host_addr,
  input wire logic [dio_pkg::BYTE_W-1:0] host_wdata,
  output logic [dio_pkg::BYTE_W-1:0] host_rdata,
  // Digital ports.
  output logic [dio_pkg::PORT_W-1:0] out_bits_low_port,
  output logic [dio_pkg::PORT_W-1:0] out_bits_high_port,
  input wire logic [dio_pkg::PORT_W-1:0] in_bits_low_port,
  input wire logic [dio_pkg::PORT_W-1:0] in_bits_high_port,
  input wire logic input_latch_pulse_low_port,
  input wire logic input_latch_pulse_high_port,
  // Counter pins and reload values.
  input wire logic [dio_pkg::GP_CHANS-1:0] gp_clock_pin,
  input wire logic event_pulse_pin,
  input wire logic [dio_pkg::GP_CHANS*dio_pkg::CNT_W-1:0] gp_reload,
  input wire logic [dio_pkg::CNT_W-1:0] event_reload,
  input wire logic [dio_pkg::CNT_W-1:0] pacer_low_reload,
  input wire logic [dio_pkg::CNT_W-1:0] pacer_high_reload,
  // Counter outputs.
  output logic [dio_pkg::GP_CHANS-1:0] gp_out,
  output logic event_irq_source,
  output logic timer_irq_source,
  // Clock source.
  input wire logic [1:0] base_clock_jumper,
  output logic [dio_pkg::PADS-1:0] clock_output_pads
);
  localparam int PW = dio_pkg::PORT_W;
  localparam int BW = dio_pkg::BYTE_W;
  localparam int GN = dio_pkg::GP_CHANS;

  // Pin synchronisers, two stages, plus one history stage for edges.
  logic [PW-1:0] in_lo_m, in_lo_s, in_hi_m, in_hi_s;
  logic [1:0] stb_m, stb_s;
  logic [GN-1:0] gp_m, gp_s, gp_d;
  logic evt_m, evt_s, evt_d;
  logic [1:0] jmp_m, jmp_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_lo_m <= '0;
      in_lo_s <= '0;
      in_hi_m <= '0;
      in_hi_s <= '0;
      stb_m <= 2'h3;
      stb_s <= 2'h3;
      gp_m <= '0;
      gp_s <= '0;
      gp_d <= '0;
      evt_m <= 1'b0;
      evt_s <= 1'b0;
      evt_d <= 1'b0;
      jmp_m <= dio_pkg::JUMPER_DEFAULT;
      jmp_s <= dio_pkg::JUMPER_DEFAULT;
    end else begin
      in_lo_m <= in_bits_low_port;
      in_lo_s <= in_lo_m;
      in_hi_m <= in_bits_high_port;
      in_hi_s <= in_hi_m;
      stb_m <= {input_latch_pulse_high_port, input_latch_pulse_low_port};
      stb_s <= stb_m;
      gp_m <= gp_clock_pin;
      gp_s <= gp_m;
      gp_d <= gp_s;
      evt_m <= event_pulse_pin;
      evt_s <= evt_m;
      evt_d <= evt_s;
      jmp_m <= base_clock_jumper;
      jmp_s <= jmp_m;
    end
  end

  // Input latches: transparent while the strobe is high, hold while low.
  logic [PW-1:0] latch_lo, latch_hi;
  logic [PW-1:0] next_latch_lo, next_latch_hi;
  assign next_latch_lo = stb_s[0] ? in_lo_s : latch_lo;
  assign next_latch_hi = stb_s[1] ? in_hi_s : latch_hi;

  // Host byte decode.
  logic sel_hi_port, sel_hi_byte;
  logic [PW-1:0] rd_port;
  logic [BW-1:0] rd_byte;
  logic wr_lo_b0, wr_lo_b1, wr_hi_b0, wr_hi_b1;
  assign sel_hi_port = host_addr[dio_pkg::PORT_SEL_BIT];
  assign sel_hi_byte = host_addr[dio_pkg::BYTE_SEL_BIT];
  assign rd_port = sel_hi_port ? latch_hi : latch_lo;
  assign rd_byte = sel_hi_byte ? rd_port[PW-1:BW] : rd_port[BW-1:0];
  assign wr_lo_b0 = host_wr && !sel_hi_port && !sel_hi_byte;
  assign wr_lo_b1 = host_wr && !sel_hi_port && sel_hi_byte;
  assign wr_hi_b0 = host_wr && sel_hi_port && !sel_hi_byte;
  assign wr_hi_b1 = host_wr && sel_hi_port && sel_hi_byte;

  logic [PW-1:0] next_out_lo, next_out_hi;
  assign next_out_lo = {wr_lo_b1 ? host_wdata : out_bits_low_port[PW-1:BW],
                        wr_lo_b0 ? host_wdata : out_bits_low_port[BW-1:0]};
  assign next_out_hi = {wr_hi_b1 ? host_wdata : out_bits_high_port[PW-1:BW],
                        wr_hi_b0 ? host_wdata : out_bits_high_port[BW-1:0]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_bits_low_port <= dio_pkg::OUT_RESET;
      out_bits_high_port <= dio_pkg::OUT_RESET;
      latch_lo <= dio_pkg::IN_DISABLED;
      latch_hi <= dio_pkg::IN_DISABLED;
      host_rdata <= dio_pkg::RDATA_RESET;
    end else begin
      out_bits_low_port <= next_out_lo;
      out_bits_high_port <= next_out_hi;
      latch_lo <= next_latch_lo;
      latch_hi <= next_latch_hi;
      host_rdata <= host_rd ? rd_byte : host_rdata;
    end
  end

  // General purpose counters, one per connector clock pin.
  logic [GN-1:0] gp_term;
  genvar gi;
  generate
    for (gi = 0; gi < GN; gi++) begin : g_gp
      dio_count_chan #(.W(dio_pkg::CNT_W)) u_gp (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(gp_s[gi] && !gp_d[gi]),
        .reload(gp_reload[gi*dio_pkg::CNT_W +: dio_pkg::CNT_W]),
        .count(),
        .terminal(gp_term[gi])
      );
    end
  endgenerate

  // Internal 4 MHz reference ticks from a phase accumulator.
  logic [dio_pkg::ACC_W-1:0] ref_acc, acc_sum, next_acc;
  logic ref_tick;
  assign acc_sum = ref_acc + dio_pkg::ACC_REF;
  assign ref_tick = (acc_sum >= dio_pkg::ACC_CLK);
  assign next_acc = ref_tick ? acc_sum - dio_pkg::ACC_CLK : acc_sum;

  logic evt_term, pl_term, ph_term;
  dio_count_chan #(.W(dio_pkg::CNT_W)) u_event (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(evt_s && !evt_d),
    .reload(event_reload),
    .count(),
    .terminal(evt_term)
  );
  dio_count_chan #(.W(dio_pkg::CNT_W)) u_pacer_lo (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(ref_tick),
    .reload(pacer_low_reload),
    .count(),
    .terminal(pl_term)
  );
  dio_count_chan #(.W(dio_pkg::CNT_W)) u_pacer_hi (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(pl_term),
    .reload(pacer_high_reload),
    .count(),
    .terminal(ph_term)
  );

  // Base clock divider and two decade stages.
  logic [dio_pkg::DIV_W-1:0] base_div, base_cnt, next_base_cnt;
  logic [dio_pkg::DEC_W-1:0] dec1, dec2, next_dec1, next_dec2;
  logic base_tick, dec1_wrap;
  logic [dio_pkg::PADS-1:0] next_pads;
  assign base_div = (jmp_s == dio_pkg::JUMPER_2M) ? dio_pkg::BASE_DIV_0 :
                    (jmp_s == dio_pkg::JUMPER_1M) ? dio_pkg::BASE_DIV_1 :
                    (jmp_s == dio_pkg::JUMPER_500K) ? dio_pkg::BASE_DIV_2 :
                    dio_pkg::BASE_DIV_3;
  assign base_tick = (base_cnt >= base_div - 1'b1);
  assign next_base_cnt = base_tick ? '0 : base_cnt + 1'b1;
  assign dec1_wrap = base_tick && (dec1 == dio_pkg::DECADE_LAST);
  assign next_dec1 = base_tick ? (dec1_wrap ? '0 : dec1 + 1'b1) : dec1;
  assign next_dec2 = dec1_wrap ? ((dec2 == dio_pkg::DECADE_LAST) ? '0 : dec2 + 1'b1) : dec2;
  assign next_pads[dio_pkg::PAD_BASE] = (base_cnt < (base_div >> 1));
  assign next_pads[dio_pkg::PAD_DIV10] = (dec1 < dio_pkg::DECADE_HALF);
  assign next_pads[dio_pkg::PAD_DIV100] = (dec2 < dio_pkg::DECADE_HALF);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_acc <= '0;
      base_cnt <= '0;
      dec1 <= '0;
      dec2 <= '0;
      clock_output_pads <= '0;
      gp_out <= '0;
      event_irq_source <= 1'b0;
      timer_irq_source <= 1'b0;
    end else begin
      ref_acc <= next_acc;
      base_cnt <= next_base_cnt;
      dec1 <= next_dec1;
      dec2 <= next_dec2;
      clock_output_pads <= next_pads;
      gp_out <= gp_term;
      event_irq_source <= evt_term;
      timer_irq_source <= ph_term;
    end
  end

  a_out_reset_low: assert property (@(posedge clk)
    sys_rst |=> (out_bits_low_port == '0) && (out_bits_high_port == '0))
    else $error("output ports not cleared by reset");
  a_in_reset_off: assert property (@(posedge clk)
    sys_rst |=> (host_rdata == '0) && (latch_lo == '0) && (latch_hi == '0))
    else $error("input path not disabled in reset");
  a_strobe_hold_low: assert property (@(posedge clk) disable iff (sys_rst)
    !stb_s[0] |=> $stable(latch_lo)) else $error("low latch moved while held");
  a_transparent_low: assert property (@(posedge clk) disable iff (sys_rst)
    stb_s[0] |=> latch_lo == $past(in_lo_s)) else $error("low port not transparent");
  a_high_strobe_map: assert property (@(posedge clk) disable iff (sys_rst)
    stb_s[1] ##1 !stb_s[1] |=> latch_hi == $past(in_hi_s, 2))
    else $error("high latch did not capture bits 16 to 31");
  a_byte_write_hi: assert property (@(posedge clk) disable iff (sys_rst)
    wr_hi_b1 |=> out_bits_high_port[PW-1:BW] == $past(host_wdata))
    else $error("high byte of high port not written");
  a_read_byte_map: assert property (@(posedge clk) disable iff (sys_rst)
    host_rd && !sel_hi_port && !sel_hi_byte |=> host_rdata == $past(latch_lo[BW-1:0]))
    else $error("low byte read mismatch");
  a_event_source: assert property (@(posedge clk) disable iff (sys_rst)
    event_irq_source |-> $past(evt_s && !evt_d, 2)) else $error("event trigger without pulse");
  a_pacer_cascade: assert property (@(posedge clk) disable iff (sys_rst)
    timer_irq_source |-> $past(pl_term, 2)) else $error("timer trigger not from cascade");
  a_decade_step: assert property (@(posedge clk) disable iff (sys_rst)
    !base_tick |=> $stable(dec1)) else $error("decade stage moved without base tick");

  c_event_irq: cover property (@(posedge clk) disable iff (sys_rst) event_irq_source);
  c_timer_irq: cover property (@(posedge clk) disable iff (sys_rst) timer_irq_source);
  c_strobe_latch: cover property (@(posedge clk) disable iff (sys_rst) stb_s[0] ##1 !stb_s[0]);
  c_div100_rise: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(clock_output_pads[dio_pkg::PAD_DIV100]));
endmodule : dio_top

// ==== dio_host_model.sv ====
// Purpose: Host side of the card's 8-bit internal data path, moving one byte per transfer.
// Assumes: Requests start after a rising edge and are taken at the next rising edge.
// Notes: Released write data shows the inverse of the last byte, never a stale copy.
`timescale 1ns/1ps
module dio_host_model (
  // Clock.
  input wire logic clk,
  // Byte transfer signals.
  input wire logic [7:0] host_rdata,
  output logic host_wr,
  output logic host_rd,
  output logic [1:0] host_addr,
  output logic [7:0] host_wdata
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 2'h0;
    host_wdata = 8'h00;
  end

  // One byte written; a 16-bit port takes two of these.
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask : wr

  // One byte read; the answer is taken one edge after the request.
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    @(posedge clk);
    d = host_rdata;
  endtask : rd
endmodule : dio_host_model

// ==== dio_top_tb.sv ====
// Purpose: Self-checking bench for the digital I/O ports, counters and clock pads.
// Assumes: 10 MHz clock; reset held for 20 cycles at the start.
// Notes: Port and strobe pin changes wait six cycles to pass the input synchronisers.
`timescale 1ns/1ps
module dio_top_tb;
  typedef struct packed {logic [1:0] a; logic [7:0] d; logic [15:0] lo, hi;} dio_row_t;
  logic clk, sys_rst, host_wr, host_rd, stb_lo, stb_hi, ev_pin, ev_irq, tmr_irq;
  logic [1:0] host_addr, jumper;
  logic [7:0] host_wdata, host_rdata;
  logic [15:0] out_lo, out_hi, in_lo, in_hi, v;
  logic [2:0] gp_pin, gp_out, pads;
  int fails, num_checks, ev_n, tmr_n, p, m;
  int gp_n [3];
  int hz [4] = '{dio_pkg::BASE_HZ_0, dio_pkg::BASE_HZ_1, dio_pkg::BASE_HZ_2, dio_pkg::BASE_HZ_3};
  dio_row_t rows [5] = '{'{2'h3, 8'ha5, 16'h0000, 16'ha500}, '{2'h0, 8'h3c, 16'h003c, 16'ha500},
    '{2'h1, 8'hff, 16'hff3c, 16'ha500}, '{2'h2, 8'h01, 16'hff3c, 16'ha501},
    '{2'h0, 8'h00, 16'hff00, 16'ha501}};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  dio_host_model host (.clk(clk), .host_rdata(host_rdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata));

  dio_top uut (.clk(clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .out_bits_low_port(out_lo), .out_bits_high_port(out_hi), .in_bits_low_port(in_lo),
    .in_bits_high_port(in_hi), .input_latch_pulse_low_port(stb_lo),
    .input_latch_pulse_high_port(stb_hi), .gp_clock_pin(gp_pin), .event_pulse_pin(ev_pin),
    .gp_reload({16'h0004, 16'h0003, 16'h0002}), .event_reload(16'h0003),
    .pacer_low_reload(16'h0002), .pacer_high_reload(16'h0002), .gp_out(gp_out),
    .event_irq_source(ev_irq), .timer_irq_source(tmr_irq), .base_clock_jumper(jumper),
    .clock_output_pads(pads));

  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) if (gp_out[i] === 1'b1) gp_n[i]++;
    if (ev_irq === 1'b1) ev_n++;
    if (tmr_irq === 1'b1) tmr_n++;
  end

  task check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : check

  task wrap_up;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task rd16(input logic port, output logic [15:0] r);
    logic [7:0] b0, b1;
    host.rd({port, 1'b0}, b0);
    host.rd({port, 1'b1}, b1);
    r = {b1, b0};
  endtask : rd16

  task rise(input int b, output int n);
    n = 1;
    @(posedge clk);
    while (pads[b] !== 1'b0 && n < 9000) begin @(posedge clk); n++; end
    while (pads[b] !== 1'b1 && n < 9000) begin @(posedge clk); n++; end
  endtask : rise

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1; in_lo = 16'hc3a5; in_hi = 16'h5a3c; stb_lo = 1'b1; stb_hi = 1'b1;
    gp_pin = 3'h0; ev_pin = 1'b0; jumper = dio_pkg::JUMPER_DEFAULT;
    fails = 0; num_checks = 0; ev_n = 0; tmr_n = 0; gp_n = '{0, 0, 0}; v = 16'h0000;
    repeat (15) @(posedge clk);
    host.wr(2'h0, 8'hff);
    host.rd(2'h0, v[7:0]);
    check({8'h00, v[7:0]}, 16'h0000);
    check(out_lo | out_hi, 16'h0000);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    check(out_lo, 16'h0000);
    rd16(1'b0, v);
    check(v, 16'hc3a5);
    rd16(1'b1, v);
    check(v, 16'h5a3c);
    $display("Test reset done");
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      @(negedge clk);
      check(out_lo, rows[i].lo);
      check(out_hi, rows[i].hi);
    end
    $display("Test write table done");
    @(posedge clk);
    in_lo <= 16'h1111; in_hi <= 16'h2222; repeat (6) @(posedge clk);
    stb_lo <= 1'b0; repeat (6) @(posedge clk);
    in_lo <= 16'h3333; in_hi <= 16'h4444; repeat (6) @(posedge clk);
    rd16(1'b0, v);
    check(v, 16'h1111);
    rd16(1'b1, v);
    check(v, 16'h4444);
    stb_lo <= 1'b1; stb_hi <= 1'b0; repeat (6) @(posedge clk);
    in_lo <= 16'h5555; in_hi <= 16'h6666; repeat (6) @(posedge clk);
    rd16(1'b0, v);
    check(v, 16'h5555);
    rd16(1'b1, v);
    check(v, 16'h4444);
    stb_hi <= 1'b1;
    $display("Test strobe done");
    sys_rst <= 1'b1; repeat (3) @(posedge clk);
    @(negedge clk);
    check(out_lo | out_hi, 16'h0000);
    host.rd(2'h1, v[7:0]);
    check({8'h00, v[7:0]}, 16'h0000);
    sys_rst <= 1'b0; repeat (6) @(posedge clk);
    $display("Test mid-run reset done");
    gp_n = '{0, 0, 0}; ev_n = 0;
    repeat (12) begin
      gp_pin <= 3'h7; ev_pin <= 1'b1; repeat (3) @(posedge clk);
      gp_pin <= 3'h0; ev_pin <= 1'b0; repeat (3) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    for (int i = 0; i < 3; i++) check(16'(gp_n[i]), 16'(1 + 11 / (i + 2)));
    check(16'(ev_n), 16'h0004);
    tmr_n = 0; repeat (1000) @(posedge clk);
    check(16'(tmr_n >= 99 && tmr_n <= 101), 16'h0001);
    $display("Test counters done");
    for (int j = 0; j < 4; j++) begin
      jumper <= 2'(j); m = 1;
      for (int b = 0; b < 3; b++) begin
        rise(b, p); rise(b, p); rise(b, p);
        check(16'(p), 16'(dio_pkg::CLK_HZ / hz[j] * m));
        m = m * 10;
      end
    end
    $display("Test clock pads done");
    wrap_up();
  end
endmodule : dio_top_tb
